// ### rtl/cmp_regs_pkg.sv
// constants for the comparator control register block
package cmp_regs_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] CMP1_CONTROL_ADDR    = 8'h9A;
  localparam logic [7:0] CMP1_MODE_ADDR       = 8'h9C;
  localparam logic [7:0] CMP0_INPUT_SEL_ADDR  = 8'h9F;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTL_ENABLE_BIT    = 7;
  localparam int CTL_RESULT_BIT    = 6;
  localparam int CTL_RISE_BIT      = 5;
  localparam int CTL_FALL_BIT      = 4;
  localparam int CTL_POS_HYST_LSB  = 2;
  localparam int CTL_NEG_HYST_LSB  = 0;
  localparam int MODE_RISE_IE_BIT  = 5;
  localparam int MODE_FALL_IE_BIT  = 4;
  localparam int MODE_RESP_LSB     = 0;
  localparam int SEL_POS_LSB       = 0;
  localparam int SEL_NEG_LSB       = 4;

  // ****************************************************************
  // reset values and field codes
  // ****************************************************************
  localparam logic [7:0] CONTROL_RESET   = 8'h00;
  localparam logic [1:0] RESP_MODE_RESET = 2'h2;
  localparam logic [2:0] SEL_RESET       = 3'h0;
  localparam logic [2:0] SEL_LAST_VALID  = 3'h4;

endpackage : cmp_regs_pkg

// ### rtl/cmp_edge_sync.sv
// synchroniser and edge detector for the asynchronous comparator output
`timescale 1ns/1ps
module cmp_edge_sync (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  // meta_ff is read only by sync_ff
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level_out = sync_ff;
  assign rise_out  = sync_ff & ~prev_ff;
  assign fall_out  = ~sync_ff & prev_ff;
endmodule : cmp_edge_sync

// ### rtl/comparator_control_regs.sv
// register bank and edge-event logic for the comparator pair
`timescale 1ns/1ps

// Notes on behaviour
// - control bit 6 shows live comparator result
// - bit 5 rise flag sticks until cleared
// - bit 4 fall flag sticks until cleared
// - bits 3:2 positive hysteresis code drives cell
// - bits 1:0 negative hysteresis, same code map
// - mode bit 5 gates rising-edge interrupt
// - mode bit 4 gates falling-edge interrupt
// - mode bits 1:0 select response mode
// - mode bits 7:6, 3:2 read zero
// - select bits 2:0 pick positive input pin
// - select bits 6:4 pick negative input pin
// - control bit 7 enables the comparator
// - output transitions set matching edge flags while bit 7 is set
// - flag with enable raises interrupt request
module comparator_control_regs
  import cmp_regs_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       reset_n_in,
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic [7:0] sfr_wdata_in,
  input  wire logic       sfr_wr_in,
  input  wire logic       sfr_rd_in,
  input  wire logic       cmp_raw_in,
  output logic      [7:0] sfr_rdata_out,
  output logic            cmp_enable_out,
  output logic      [1:0] cmp_pos_hyst_out,
  output logic      [1:0] cmp_neg_hyst_out,
  output logic      [1:0] cmp_response_mode_out,
  output logic      [2:0] pos_input_select_out,
  output logic      [2:0] neg_input_select_out,
  output logic            cmp_irq_out
);
  import cmp_regs_pkg::*;

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ****************************************************************
  // comparator result sampling
  // ****************************************************************
  logic result_level;
  logic result_rise;
  logic result_fall;

  cmp_edge_sync u_edge_sync (
    .clk_in    (clk_sys_in),
    .rst_n_in  (rst_sync_ff),
    .async_in  (cmp_raw_in),
    .level_out (result_level),
    .rise_out  (result_rise),
    .fall_out  (result_fall)
  );

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic wr_ctl;
  logic wr_mode;
  logic wr_sel;

  always_comb begin
    wr_ctl  = sfr_wr_in && (sfr_addr_in == CMP1_CONTROL_ADDR);
    wr_mode = sfr_wr_in && (sfr_addr_in == CMP1_MODE_ADDR);
    wr_sel  = sfr_wr_in && (sfr_addr_in == CMP0_INPUT_SEL_ADDR);
  end

  // ****************************************************************
  // control register: enable, edge flags, hysteresis
  // ****************************************************************
  logic       enable_ff,    nxt_enable;
  logic       rise_flag_ff, nxt_rise_flag;
  logic       fall_flag_ff, nxt_fall_flag;
  logic [1:0] pos_hyst_ff,  nxt_pos_hyst;
  logic [1:0] neg_hyst_ff,  nxt_neg_hyst;

  always_comb begin
    nxt_enable   = wr_ctl ? sfr_wdata_in[CTL_ENABLE_BIT] : enable_ff;
    nxt_pos_hyst = wr_ctl ? sfr_wdata_in[CTL_POS_HYST_LSB +: 2] : pos_hyst_ff;
    nxt_neg_hyst = wr_ctl ? sfr_wdata_in[CTL_NEG_HYST_LSB +: 2] : neg_hyst_ff;

    // software may write a flag either way; a same-cycle edge still wins
    nxt_rise_flag = wr_ctl ? sfr_wdata_in[CTL_RISE_BIT] : rise_flag_ff;
    nxt_fall_flag = wr_ctl ? sfr_wdata_in[CTL_FALL_BIT] : fall_flag_ff;
    // a disabled comparator reports no edges; this also hides the false
    // rise the synchroniser sees when the pin is already high at reset
    if (enable_ff && result_rise) begin
      nxt_rise_flag = 1'b1;
    end
    if (enable_ff && result_fall) begin
      nxt_fall_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      enable_ff    <= CONTROL_RESET[CTL_ENABLE_BIT];
      rise_flag_ff <= CONTROL_RESET[CTL_RISE_BIT];
      fall_flag_ff <= CONTROL_RESET[CTL_FALL_BIT];
      pos_hyst_ff  <= CONTROL_RESET[CTL_POS_HYST_LSB +: 2];
      neg_hyst_ff  <= CONTROL_RESET[CTL_NEG_HYST_LSB +: 2];
    end else begin
      enable_ff    <= nxt_enable;
      rise_flag_ff <= nxt_rise_flag;
      fall_flag_ff <= nxt_fall_flag;
      pos_hyst_ff  <= nxt_pos_hyst;
      neg_hyst_ff  <= nxt_neg_hyst;
    end
  end

  // ****************************************************************
  // mode register: interrupt enables and response mode
  // ****************************************************************
  logic       rise_ie_ff, nxt_rise_ie;
  logic       fall_ie_ff, nxt_fall_ie;
  logic [1:0] resp_ff,    nxt_resp;

  always_comb begin
    nxt_rise_ie = wr_mode ? sfr_wdata_in[MODE_RISE_IE_BIT] : rise_ie_ff;
    nxt_fall_ie = wr_mode ? sfr_wdata_in[MODE_FALL_IE_BIT] : fall_ie_ff;
    nxt_resp    = wr_mode ? sfr_wdata_in[MODE_RESP_LSB +: 2] : resp_ff;
  end

  always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rise_ie_ff <= 1'b0;
      fall_ie_ff <= 1'b0;
      resp_ff    <= RESP_MODE_RESET;
    end else begin
      rise_ie_ff <= nxt_rise_ie;
      fall_ie_ff <= nxt_fall_ie;
      resp_ff    <= nxt_resp;
    end
  end

  // ****************************************************************
  // input select register
  // ****************************************************************
  logic [2:0] pos_sel_ff, nxt_pos_sel;
  logic [2:0] neg_sel_ff, nxt_neg_sel;

  always_comb begin
    nxt_pos_sel = wr_sel ? sfr_wdata_in[SEL_POS_LSB +: 3] : pos_sel_ff;
    nxt_neg_sel = wr_sel ? sfr_wdata_in[SEL_NEG_LSB +: 3] : neg_sel_ff;
  end

  always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      pos_sel_ff <= SEL_RESET;
      neg_sel_ff <= SEL_RESET;
    end else begin
      pos_sel_ff <= nxt_pos_sel;
      neg_sel_ff <= nxt_neg_sel;
    end
  end

  // ****************************************************************
  // interrupt request
  // ****************************************************************
  logic irq_ff, nxt_irq;

  // built from next values so the request moves on the same edge as its flag
  always_comb begin
    nxt_irq = (nxt_rise_flag && nxt_rise_ie) || (nxt_fall_flag && nxt_fall_ie);
  end

  always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  logic [7:0] ctl_view;
  logic [7:0] mode_view;
  logic [7:0] sel_view;
  logic [7:0] rdata_ff, nxt_rdata;

  always_comb begin
    ctl_view = 8'h00;
    ctl_view[CTL_ENABLE_BIT] = enable_ff;
    ctl_view[CTL_RESULT_BIT] = result_level;
    ctl_view[CTL_RISE_BIT]   = rise_flag_ff;
    ctl_view[CTL_FALL_BIT]   = fall_flag_ff;
    ctl_view[CTL_POS_HYST_LSB +: 2] = pos_hyst_ff;
    ctl_view[CTL_NEG_HYST_LSB +: 2] = neg_hyst_ff;

    // unused mode bits stay zero
    mode_view = 8'h00;
    mode_view[MODE_RISE_IE_BIT] = rise_ie_ff;
    mode_view[MODE_FALL_IE_BIT] = fall_ie_ff;
    mode_view[MODE_RESP_LSB +: 2] = resp_ff;

    sel_view = 8'h00;
    sel_view[SEL_POS_LSB +: 3] = pos_sel_ff;
    sel_view[SEL_NEG_LSB +: 3] = neg_sel_ff;

    if (sfr_rd_in) begin
      case (sfr_addr_in)
        CMP1_CONTROL_ADDR:   nxt_rdata = ctl_view;
        CMP1_MODE_ADDR:      nxt_rdata = mode_view;
        CMP0_INPUT_SEL_ADDR: nxt_rdata = sel_view;
        default:             nxt_rdata = 8'h00;
      endcase
    end else begin
      nxt_rdata = rdata_ff;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ****************************************************************
  // outputs, all from flip-flops
  // ****************************************************************
  assign sfr_rdata_out         = rdata_ff;
  assign cmp_enable_out        = enable_ff;
  assign cmp_pos_hyst_out      = pos_hyst_ff;
  assign cmp_neg_hyst_out      = neg_hyst_ff;
  assign cmp_response_mode_out = resp_ff;
  // reserved select codes pass through unchanged; the analog mux leaves them open
  assign pos_input_select_out  = pos_sel_ff;
  assign neg_input_select_out  = neg_sel_ff;
  assign cmp_irq_out           = irq_ff;

endmodule : comparator_control_regs

// ### tb/comparator_control_regs_props.sv
// port-level checks for the comparator register block
`timescale 1ns/1ps
module comparator_control_regs_props
  import cmp_regs_pkg::*;
(
  input wire logic       clk_sys_in,
  input wire logic       reset_n_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic       sfr_wr_in,
  input wire logic       sfr_rd_in,
  input wire logic       cmp_raw_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic       cmp_enable_out,
  input wire logic [1:0] cmp_pos_hyst_out,
  input wire logic [1:0] cmp_neg_hyst_out,
  input wire logic [1:0] cmp_response_mode_out,
  input wire logic [2:0] pos_input_select_out,
  input wire logic [2:0] neg_input_select_out,
  input wire logic       cmp_irq_out
);
  // the block holds its own reset for two edges after the pin rises
  logic [1:0] release_cnt_ff;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      release_cnt_ff <= 2'h0;
    end else if (release_cnt_ff != 2'h3) begin
      release_cnt_ff <= release_cnt_ff + 2'h1;
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in || release_cnt_ff != 2'h3);
  wire ctl_wr  = sfr_wr_in && sfr_addr_in == CMP1_CONTROL_ADDR;
  wire mode_wr = sfr_wr_in && sfr_addr_in == CMP1_MODE_ADDR;
  wire sel_wr  = sfr_wr_in && sfr_addr_in == CMP0_INPUT_SEL_ADDR;
  wire ctl_rd  = sfr_rd_in && sfr_addr_in == CMP1_CONTROL_ADDR;
  // ****************************************************************
  // properties
  // ****************************************************************
  // four samples cover the two-flop lag with a cycle to spare
  sequence raw_high_s; cmp_raw_in [*4]; endsequence
  sequence raw_low_s; !cmp_raw_in [*4]; endsequence
  a_ctl_write_lands: assert property (ctl_wr |=> cmp_enable_out == $past(sfr_wdata_in[7])
    && {cmp_pos_hyst_out, cmp_neg_hyst_out} == $past(sfr_wdata_in[3:0])) else $error("ctl");
  a_enable_holds: assert property (!ctl_wr |=> $stable(cmp_enable_out))
    else $error("enable moved");
  a_mode_write_lands: assert property (mode_wr |=>
    cmp_response_mode_out == $past(sfr_wdata_in[1:0])) else $error("mode");
  a_mode_unused_zero: assert property (sfr_rd_in && sfr_addr_in == CMP1_MODE_ADDR
    |=> sfr_rdata_out[7:6] == 2'h0 && sfr_rdata_out[3:2] == 2'h0) else $error("unused");
  a_sel_write_lands: assert property (sel_wr |=>
    {neg_input_select_out, pos_input_select_out} == {$past(sfr_wdata_in[6:4]),
    $past(sfr_wdata_in[2:0])}) else $error("select");
  a_irq_masked_off: assert property (mode_wr && sfr_wdata_in[5:4] == 2'h0
    |=> !cmp_irq_out ##1 ($past(mode_wr) || !cmp_irq_out)) else $error("irq masked");
  a_result_high: assert property (raw_high_s ##0 ctl_rd |=> sfr_rdata_out[6])
    else $error("result high");
  a_result_low: assert property (raw_low_s ##0 ctl_rd |=> !sfr_rdata_out[6])
    else $error("result low");
endmodule : comparator_control_regs_props
bind comparator_control_regs comparator_control_regs_props chk (.clk_sys_in, .reset_n_in,
  .sfr_addr_in, .sfr_wdata_in, .sfr_wr_in, .sfr_rd_in, .cmp_raw_in, .sfr_rdata_out,
  .cmp_enable_out, .cmp_pos_hyst_out, .cmp_neg_hyst_out, .cmp_response_mode_out,
  .pos_input_select_out, .neg_input_select_out, .cmp_irq_out);

// ### tb/comparator_control_regs_test.sv
// self-checking bench for the comparator register block
`timescale 1ns/1ps
module comparator_control_regs_test;
  import cmp_regs_pkg::*;
  logic       clk_sys_in, reset_n_in, sfr_wr_in, sfr_rd_in, cmp_raw_in, cmp_enable_out, cmp_irq_out;
  logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out;
  logic [1:0] cmp_pos_hyst_out, cmp_neg_hyst_out, cmp_response_mode_out;
  logic [2:0] pos_input_select_out, neg_input_select_out;
  int         failures, checked, cycles;
  comparator_control_regs DUT (.clk_sys_in, .reset_n_in, .sfr_addr_in, .sfr_wdata_in, .sfr_wr_in,
    .sfr_rd_in, .cmp_raw_in, .sfr_rdata_out, .cmp_enable_out, .cmp_pos_hyst_out, .cmp_neg_hyst_out,
    .cmp_response_mode_out, .pos_input_select_out, .neg_input_select_out, .cmp_irq_out);
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  // ****************************************************************
  // bus tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    sfr_wr_in    <= 1'b1;
    sfr_addr_in  <= a;
    sfr_wdata_in <= d;
    @(posedge clk_sys_in);
    sfr_wr_in <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_in);
    sfr_rd_in   <= 1'b1;
    sfr_addr_in <= a;
    @(posedge clk_sys_in);
    sfr_rd_in <= 1'b0;
    #1;
    chk($sformatf("rdata %h", a), exp, sfr_rdata_out);
  endtask : rd
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    rd(CMP1_CONTROL_ADDR, CONTROL_RESET);
    rd(CMP1_MODE_ADDR, {6'h00, RESP_MODE_RESET});
    rd(CMP0_INPUT_SEL_ADDR, 8'h00);
    rd(8'h9B, 8'h00);
  endtask : t_reset
  task automatic t_mode;
    for (int m = 0; m < 4; m++) begin
      wr(CMP1_MODE_ADDR, {2'h3, m[1:0], 2'h3, m[1:0]});
      chk("mode", {6'h00, m[1:0]}, {6'h00, cmp_response_mode_out});
      rd(CMP1_MODE_ADDR, {2'h0, m[1:0], 2'h0, m[1:0]});
    end
  endtask : t_mode
  task automatic t_ctl;
    // bit 6 written high must not stick; input is low so it reads 0
    for (int i = 0; i < 16; i++) begin
      wr(CMP1_CONTROL_ADDR, {4'h4, i[3:0]});
      chk("hyst", {4'h0, i[3:0]}, {4'h0, cmp_pos_hyst_out, cmp_neg_hyst_out});
      rd(CMP1_CONTROL_ADDR, {4'h0, i[3:0]});
    end
  endtask : t_ctl
  task automatic t_sel;
    for (int i = 0; i < 8; i++) begin
      wr(CMP0_INPUT_SEL_ADDR, {1'b1, i[2:0], 1'b1, ~i[2:0]});
      chk("sel", {1'b0, i[2:0], 1'b0, ~i[2:0]},
        {1'b0, neg_input_select_out, 1'b0, pos_input_select_out});
      rd(CMP0_INPUT_SEL_ADDR, {1'b0, i[2:0], 1'b0, ~i[2:0]});
    end
  endtask : t_sel
  task automatic t_edges;
    wr(CMP1_CONTROL_ADDR, 8'h80);
    chk("enable", 8'h01, {7'h00, cmp_enable_out});
    wr(CMP1_MODE_ADDR, 8'h02);
    wr(CMP1_CONTROL_ADDR, 8'h80);
    @(posedge clk_sys_in);
    cmp_raw_in <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
    rd(CMP1_CONTROL_ADDR, 8'hE0);
    chk("irq", 8'h00, {7'h00, cmp_irq_out});
    wr(CMP1_MODE_ADDR, 8'h22);
    chk("irq", 8'h01, {7'h00, cmp_irq_out});
    wr(CMP1_CONTROL_ADDR, 8'h80);
    rd(CMP1_CONTROL_ADDR, 8'hC0);
    @(posedge clk_sys_in);
    cmp_raw_in <= 1'b0;
    repeat (5) @(posedge clk_sys_in);
    rd(CMP1_CONTROL_ADDR, 8'h90);
    chk("irq", 8'h00, {7'h00, cmp_irq_out});
    wr(CMP1_MODE_ADDR, 8'h12);
    chk("irq", 8'h01, {7'h00, cmp_irq_out});
    repeat (10) @(posedge clk_sys_in);
    rd(CMP1_CONTROL_ADDR, 8'h90);
    wr(CMP1_CONTROL_ADDR, 8'h00);
    @(posedge clk_sys_in);
    cmp_raw_in <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
    rd(CMP1_CONTROL_ADDR, 8'h40);
  endtask : t_edges
  task automatic tally_and_finish;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  // hang guard: the whole sequence needs well under 1000 cycles
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    {reset_n_in, sfr_wr_in, sfr_rd_in, cmp_raw_in} = 4'h0;
    {sfr_addr_in, sfr_wdata_in} = 16'h0000;
    {failures, checked, cycles} = '0;
    repeat (8) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    t_reset();
    t_mode();
    t_ctl();
    t_sel();
    t_edges();
    tally_and_finish();
  end
endmodule : comparator_control_regs_test
